// *** shared/rpsel_pin_if.sv ***
// Purpose: Carries one pin's function selection to its output mux and the result back.
// Assumes: One instance per remappable output pin.
// Notes:   The mux registers both results.
`timescale 1ns/10ps
interface rpsel_pin_if;
	logic [4:0] func_sel;
	logic       pin_val;
	logic       remapped;
	modport ctrl (output func_sel, input pin_val, input remapped);
	modport mux  (input func_sel, output pin_val, output remapped);
endinterface : rpsel_pin_if

// *** shared/rpsel_pkg.sv ***
// Purpose: Shared constants for the remappable pin select register block.
// Assumes: AHB-Lite register access with 32-bit aligned words.
// Notes:   Offsets are byte addresses; each register takes one word.
package rpsel_pkg;

	// Width of every pin or function selection field.
	localparam int RPSEL_FW = 5;

	// Byte offsets of the registers.
	localparam logic [31:0] RPSEL_OFF_SS_MAP   = 32'h0000_0000;
	localparam logic [31:0] RPSEL_OFF_OUT_MAP0 = 32'h0000_0004;
	localparam logic [31:0] RPSEL_OFF_OUT_LAST = 32'h0000_0014;

	// Bit positions of the two fields within a register.
	localparam int RPSEL_LO_LSB = 0;
	localparam int RPSEL_HI_LSB = 8;

	// Values after power-on reset.
	localparam logic [4:0] RPSEL_SS_RESET  = 5'h1f;
	localparam logic [4:0] RPSEL_FLD_RESET = 5'h00;

	// Function code that leaves a pin under ordinary port control.
	localparam logic [4:0] RPSEL_FUNC_NONE = 5'h00;

	// Number of output map registers and pins they cover.
	localparam int RPSEL_MAP_COUNT = 5;
	localparam int RPSEL_OUT_PINS  = 10;

	// Only whole-word transfers write a register.
	localparam logic [2:0] RPSEL_HSIZE_WORD = 3'h2;

endpackage : rpsel_pkg

// *** src/rpsel_pin_mux.sv ***
// Purpose: Output mux for one remappable pin.
// Assumes: Peripheral output vector is indexed by function number.
// Notes:   Zero or unknown codes hand the pin back to the port latch.
`timescale 1ns/10ps
module rpsel_pin_mux
	import rpsel_pkg::*;
#(
	parameter int FUNC_COUNT = 19
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic [FUNC_COUNT-1:0] periph_out,
	input  wire logic                  port_val,
	rpsel_pin_if.mux                   pif
);

	typedef struct packed {
		logic pin_val;
		logic remapped;
	} rpsel_mux_t;

	rpsel_mux_t st_q;
	rpsel_mux_t st_d;
	logic       code_ok;

	// A code picks a peripheral only when non-zero and within the function table.
	always_comb begin
		code_ok = (pif.func_sel != RPSEL_FUNC_NONE) && (int'(pif.func_sel) < FUNC_COUNT);
		st_d = st_q;
		st_d.remapped = code_ok;
		if (code_ok) begin
			st_d.pin_val = periph_out[pif.func_sel];
		end else begin
			st_d.pin_val = port_val;
		end
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pif.pin_val  = st_q.pin_val;
	assign pif.remapped = st_q.remapped;

	// The release edge still loads reset values, so attempts made there are skipped.
	property p_mux_func;
		@(posedge hclk) disable iff (!hresetn)
		hresetn && code_ok |=> (pif.pin_val == $past(periph_out[pif.func_sel])) && pif.remapped;
	endproperty
	a_mux_func: assert property (p_mux_func) else $error("Pin does not follow its peripheral.");

	property p_mux_port;
		@(posedge hclk) disable iff (!hresetn)
		hresetn && !code_ok |=> (pif.pin_val == $past(port_val)) && !pif.remapped;
	endproperty
	a_mux_port: assert property (p_mux_port) else $error("Unmapped pin left port control.");

endmodule : rpsel_pin_mux

// *** src/rpsel_regs.sv ***
// Purpose: Remappable pin select registers with slave-select input routing and pin output muxes.
// Assumes: AHB-Lite slave, single word transfers, zero wait states, OKAY response always.
// Notes:   Read data for an address phase is built from the post-write view of the registers.
//
// Summary of operation
// - Slave-select pin choice is bits 4-0; other bits read zero.
// - Slave-select pin choice resets to all ones and is read/write.
// - Choice 00000 routes remappable pin 0 to the SPI slave-select input.
// - Output map bits 15-13 read zero and ignore writes.
// - Output map bits 7-5 read zero and ignore writes.
// - Every output function field is read/write and resets to zero.
// - First output map bits 12-8 pick the function for pin 1.
// - First output map bits 4-0 pick the function for pin 0.
// - Second output map: bits 12-8 pin 3, bits 4-0 pin 2.
// - Third output map: bits 12-8 pin 5, bits 4-0 pin 4.
// - Fourth output map: bits 12-8 pin 7, bits 4-0 pin 6.
// - Fifth output map: bits 12-8 pin 9, bits 4-0 pin 8.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module rpsel_regs
	import rpsel_pkg::*;
#(
	parameter int PIN_COUNT  = 26,
	parameter int FUNC_COUNT = 19
) (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic [31:0]                    hrdata,
	input  wire logic [FUNC_COUNT-1:0]     periph_out,
	input  wire logic [RPSEL_OUT_PINS-1:0] port_out,
	input  wire logic [PIN_COUNT-1:0]      pin_in,
	output logic [RPSEL_OUT_PINS-1:0]      pin_out,
	output logic [RPSEL_OUT_PINS-1:0]      pin_remapped,
	output logic                           spi_ss_in
);

	typedef struct packed {
		logic [4:0]                     slave_select_pin_choice;
		logic [RPSEL_OUT_PINS-1:0][4:0] fld;
		logic                           dp_valid;
		logic                           dp_write;
		logic                           dp_mapped;
		logic [2:0]                     dp_idx;
		logic [31:0]                    rdata;
		logic                           ready;
		logic                           ss_in;
	} rpsel_regs_t;

	localparam rpsel_regs_t RPSEL_REGS_RESET = '{
		slave_select_pin_choice: RPSEL_SS_RESET,
		fld:                     {RPSEL_OUT_PINS{RPSEL_FLD_RESET}},
		ready:                   1'b1,
		default:                 '0
	};

	rpsel_regs_t st_q;
	rpsel_regs_t st_d;
	logic        addr_take;
	logic [2:0]  addr_idx;
	logic        addr_mapped;
	logic [2:0]  wr_map;
	logic [2:0]  rd_map;

	// Address phase decode of the word index.
	assign addr_take   = hsel && htrans[1] && hready;
	assign addr_idx    = haddr[4:2];
	assign addr_mapped = (haddr[31:5] == 27'h000_0000)
		&& (addr_idx <= RPSEL_OFF_OUT_LAST[4:2]);
	assign wr_map      = st_q.dp_idx - RPSEL_OFF_OUT_MAP0[4:2];
	assign rd_map      = addr_idx - RPSEL_OFF_OUT_MAP0[4:2];

	// Next state: data phase write first, then address phase capture and read data.
	always_comb begin
		st_d = st_q;
		st_d.ready = 1'b1;
		if (st_q.dp_valid && st_q.dp_write && st_q.dp_mapped) begin
			if (st_q.dp_idx == RPSEL_OFF_SS_MAP[4:2]) begin
				st_d.slave_select_pin_choice = hwdata[RPSEL_LO_LSB +: RPSEL_FW];
			end else begin
				// Map k holds pins 2k (low field) and 2k+1 (high field).
				st_d.fld[{wr_map, 1'b0}] = hwdata[RPSEL_LO_LSB +: RPSEL_FW];
				st_d.fld[{wr_map, 1'b1}] = hwdata[RPSEL_HI_LSB +: RPSEL_FW];
			end
		end
		st_d.dp_valid  = addr_take;
		st_d.dp_write  = hwrite && (hsize == RPSEL_HSIZE_WORD);
		st_d.dp_mapped = addr_mapped;
		st_d.dp_idx    = addr_idx;
		// Unimplemented and unmapped bits read as zero.
		st_d.rdata = '0;
		if (addr_take && !hwrite && addr_mapped) begin
			if (addr_idx == RPSEL_OFF_SS_MAP[4:2]) begin
				st_d.rdata[RPSEL_LO_LSB +: RPSEL_FW] = st_d.slave_select_pin_choice;
			end else begin
				st_d.rdata[RPSEL_LO_LSB +: RPSEL_FW] = st_d.fld[{rd_map, 1'b0}];
				st_d.rdata[RPSEL_HI_LSB +: RPSEL_FW] = st_d.fld[{rd_map, 1'b1}];
			end
		end
		// Choices past the last pin tie the input low.
		if (int'(st_q.slave_select_pin_choice) < PIN_COUNT) begin
			st_d.ss_in = pin_in[st_q.slave_select_pin_choice];
		end else begin
			st_d.ss_in = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= RPSEL_REGS_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign hreadyout = st_q.ready;
	assign hresp     = 1'b0;
	assign hrdata    = st_q.rdata;
	assign spi_ss_in = st_q.ss_in;

	rpsel_pin_if pif [RPSEL_OUT_PINS] ();

	// One registered output mux per remappable pin.
	for (genvar i = 0; i < RPSEL_OUT_PINS; i++) begin : g_pin
		assign pif[i].func_sel = st_q.fld[i];
		rpsel_pin_mux #(
			.FUNC_COUNT (FUNC_COUNT)
		) u_mux (
			.hclk       (hclk),
			.hresetn    (hresetn),
			.periph_out (periph_out),
			.port_val   (port_out[i]),
			.pif        (pif[i])
		);
		assign pin_out[i]      = pif[i].pin_val;
		assign pin_remapped[i] = pif[i].remapped;
	end

	// Helper views for the checks below.
	logic dp_read;
	logic dp_wr;
	assign dp_read = st_q.dp_valid && !st_q.dp_write && st_q.dp_mapped;
	assign dp_wr   = st_q.dp_valid && st_q.dp_write && st_q.dp_mapped;

	// Data phases sorted by the word that they address.
	sequence s_ss_read;
		dp_read && (st_q.dp_idx == RPSEL_OFF_SS_MAP[4:2]);
	endsequence

	sequence s_map_read;
		dp_read && (st_q.dp_idx != RPSEL_OFF_SS_MAP[4:2]);
	endsequence

	sequence s_map_write;
		dp_wr && (st_q.dp_idx != RPSEL_OFF_SS_MAP[4:2]);
	endsequence

	// Select reads show zero above bit 4.
	property p_ss_upper_zero;
		@(posedge hclk) disable iff (!hresetn)
		s_ss_read |-> (hrdata[31:5] == 27'h000_0000);
	endproperty
	a_ss_upper_zero: assert property (p_ss_upper_zero) else $error("Select upper bits not zero.");

	// The select choice comes out of reset as all ones.
	property p_ss_reset;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (st_q.slave_select_pin_choice == RPSEL_SS_RESET);
	endproperty
	a_ss_reset: assert property (p_ss_reset) else $error("Select choice not all ones at reset.");

	// A select write lands in the choice on the next edge.
	property p_ss_write;
		@(posedge hclk) disable iff (!hresetn)
		(dp_wr && (st_q.dp_idx == RPSEL_OFF_SS_MAP[4:2]))
		|=> (st_q.slave_select_pin_choice == $past(hwdata[4:0]));
	endproperty
	a_ss_write: assert property (p_ss_write) else $error("Select choice write lost.");

	// Choice zero routes pin 0 to the select input.
	property p_ss_route0;
		@(posedge hclk) disable iff (!hresetn)
		(st_q.slave_select_pin_choice == 5'h00) |=> (spi_ss_in == $past(pin_in[0]));
	endproperty
	a_ss_route0: assert property (p_ss_route0) else $error("Pin 0 not routed to select.");

	// Map reads show zero in bits 15-13 and above.
	property p_map_top_zero;
		@(posedge hclk) disable iff (!hresetn)
		s_map_read |-> (hrdata[15:13] == 3'h0) && (hrdata[31:16] == 16'h0000);
	endproperty
	a_map_top_zero: assert property (p_map_top_zero) else $error("Map bits 15-13 not zero.");

	// Map reads show zero in bits 7-5.
	property p_map_mid_zero;
		@(posedge hclk) disable iff (!hresetn)
		s_map_read |-> (hrdata[7:5] == 3'h0);
	endproperty
	a_map_mid_zero: assert property (p_map_mid_zero) else $error("Map bits 7-5 not zero.");

	// All fields and pin flags come out of reset as zero.
	property p_fld_reset;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (st_q.fld == '0) && (pin_remapped == '0);
	endproperty
	a_fld_reset: assert property (p_fld_reset) else $error("Function fields not zero at reset.");

	// A map write lands in the two fields of its pin pair.
	property p_map_write;
		@(posedge hclk) disable iff (!hresetn)
		s_map_write |=> (st_q.fld[{$past(wr_map), 1'b0}] == $past(hwdata[4:0]))
			&& (st_q.fld[{$past(wr_map), 1'b1}] == $past(hwdata[12:8]));
	endproperty
	a_map_write: assert property (p_map_write) else $error("Map write to wrong pin field.");

	// The select word reads back the choice held in this data phase.
	property p_ss_read_value;
		@(posedge hclk) disable iff (!hresetn)
		s_ss_read |-> (hrdata[4:0] == st_q.slave_select_pin_choice);
	endproperty
	a_ss_read_value: assert property (p_ss_read_value) else $error("Select read data wrong.");

	// A map word reads back the field of its even pin in bits 4-0.
	property p_map_read_lo;
		@(posedge hclk) disable iff (!hresetn)
		s_map_read |-> (hrdata[4:0] == st_q.fld[{wr_map, 1'b0}]);
	endproperty
	a_map_read_lo: assert property (p_map_read_lo) else $error("Low field read wrong.");

	// A map word reads back the field of its odd pin in bits 12-8.
	property p_map_read_hi;
		@(posedge hclk) disable iff (!hresetn)
		s_map_read |-> (hrdata[12:8] == st_q.fld[{wr_map, 1'b1}]);
	endproperty
	a_map_read_hi: assert property (p_map_read_hi) else $error("High field read wrong.");

	// Read data stays zero outside a mapped read data phase.
	property p_rdata_idle;
		@(posedge hclk) disable iff (!hresetn)
		!dp_read |-> (hrdata == 32'h0000_0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not zero.");

	// Fields and choice change only through a mapped word write.
	property p_hold_no_write;
		@(posedge hclk) disable iff (!hresetn)
		!dp_wr
		|=> $stable(st_q.fld) && $stable(st_q.slave_select_pin_choice);
	endproperty
	a_hold_no_write: assert property (p_hold_no_write) else $error("Register changed unwritten.");

	// A select write leaves every output field alone.
	property p_ss_write_keep;
		@(posedge hclk) disable iff (!hresetn)
		(dp_wr && (st_q.dp_idx == RPSEL_OFF_SS_MAP[4:2]))
		|=> $stable(st_q.fld);
	endproperty
	a_ss_write_keep: assert property (p_ss_write_keep) else $error("Select write hit a field.");

	// A map write leaves the select choice alone.
	property p_map_write_keep;
		@(posedge hclk) disable iff (!hresetn)
		s_map_write |=> $stable(st_q.slave_select_pin_choice);
	endproperty
	a_map_write_keep: assert property (p_map_write_keep) else $error("Map write hit the choice.");

	// Choices past the last pin hold the select input low.
	property p_ss_out_range;
		@(posedge hclk) disable iff (!hresetn)
		(int'(st_q.slave_select_pin_choice) >= PIN_COUNT) |=> !spi_ss_in;
	endproperty
	a_ss_out_range: assert property (p_ss_out_range) else $error("Unused choice not low.");

	// The highest valid choice routes the last remappable pin.
	property p_ss_route_top;
		@(posedge hclk) disable iff (!hresetn)
		(st_q.slave_select_pin_choice == 5'(PIN_COUNT - 1))
		|=> (spi_ss_in == $past(pin_in[PIN_COUNT-1]));
	endproperty
	a_ss_route_top: assert property (p_ss_route_top) else $error("Top choice not routed.");

	// Reset releases with the select input low and no read data.
	property p_reset_outputs;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> !spi_ss_in && (hrdata == 32'h0000_0000);
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) else $error("Outputs not idle at reset.");

	// With every field zero no pin is handed to a peripheral.
	property p_all_port;
		@(posedge hclk) disable iff (!hresetn)
		(st_q.fld == '0) |=> (pin_remapped == '0);
	endproperty
	a_all_port: assert property (p_all_port) else $error("Pin remapped with zero field.");

endmodule : rpsel_regs

// *** tb/remappable_pin_select_regs_tb.sv ***
// Purpose: Self-checking bench for the remappable pin select registers.
// Assumes: Zero-wait AHB-Lite slave; pins follow their sources one edge later.
// Notes:   Pin expectations use inputs sampled at the falling edge before the update.
`timescale 1ns/10ps
module remappable_pin_select_regs_tb;
	import rpsel_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, spi_ss_in;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [18:0] periph_out;
	logic [9:0]  port_out, pin_out, pin_remapped;
	logic [25:0] pin_in;
	logic [4:0]  fld [10];
	logic [4:0]  ss;
	int          n_errors, n_checks, cyc;

	rpsel_periph_model i_peer (.hclk(hclk), .hresetn(hresetn), .periph_out(periph_out),
		.port_out(port_out), .pin_in(pin_in));
	rpsel_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.periph_out(periph_out), .port_out(port_out), .pin_in(pin_in), .pin_out(pin_out),
		.pin_remapped(pin_remapped), .spi_ss_in(spi_ss_in));

	// Clock of 50 ns period.
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// Cuts a hang short well beyond the hundred or so cycles the tests need.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end

	// Compares one value and counts the result.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask : chk

	// One single word transfer; read data lands in rd.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= RPSEL_HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask : ahb

	// Checks pin levels and the routed select input in three rounds of two cycles.
	task automatic pins;
		logic [9:0] ep, er;
		logic       es;
		repeat (3) begin
			@(negedge hclk);
			for (int k = 0; k < 10; k++) begin
				er[k] = (fld[k] != 5'h00) && (fld[k] < 5'h13);
				ep[k] = er[k] ? periph_out[fld[k]] : port_out[k];
			end
			es = (ss < 5'h1a) ? pin_in[ss] : 1'b0;
			@(negedge hclk);
			chk("pin_out", {22'h0, ep}, {22'h0, pin_out});
			chk("pin_remapped", {22'h0, er}, {22'h0, pin_remapped});
			chk("spi_ss_in", {31'h0, es}, {31'h0, spi_ss_in});
		end
		@(posedge hclk);
	endtask : pins

	// Reset values of every word, the two unmapped words included.
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			ahb(1'b0, 32'(4 * i), 32'h0000_0000);
			chk("reset_word", (i == 0) ? 32'h0000_001f : 32'h0000_0000, rd);
		end
		pins();
		$display("test reset done");
	endtask : t_reset

	// Field masks, field-to-pin pairing, zero and undefined codes.
	task automatic t_maps;
		for (int i = 1; i < 6; i++) begin
			ahb(1'b1, 32'(4 * i), 32'hffff_ffff);
			ahb(1'b0, 32'(4 * i), 32'h0000_0000);
			chk("map_mask", 32'h0000_1f1f, rd);
		end
		for (int i = 0; i < 5; i++) begin
			fld[2 * i] = 5'(2 * i + 1);
			fld[2 * i + 1] = 5'(2 * i + 10);
			ahb(1'b1, 32'(4 * i + 4), {19'h0, fld[2 * i + 1], 3'h0, fld[2 * i]});
		end
		pins();
		fld[0] = 5'h00;
		fld[1] = 5'h19;
		ahb(1'b1, 32'h0000_0004, 32'h0000_1900);
		pins();
		$display("test maps done");
	endtask : t_maps

	// Select choice zero, the top pin, the mask and an ignored unmapped write.
	task automatic t_ss;
		ahb(1'b1, 32'h0000_0000, 32'hffff_ffe0);
		ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
		chk("ss_zero", 32'h0000_0000, rd);
		ss = 5'h00;
		pins();
		ahb(1'b1, 32'h0000_0000, 32'h0000_0019);
		ss = 5'h19;
		pins();
		ahb(1'b1, 32'h0000_0018, 32'hffff_ffff);
		ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
		chk("ss_keep", 32'h0000_0019, rd);
		$display("test select done");
	endtask : t_ss

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// Main sequence.
	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		foreach (fld[k]) fld[k] = 5'h00;
		ss = 5'h1f;
		hresetn = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_maps();
		t_ss();
		wrap_up();
	end
endmodule : remappable_pin_select_regs_tb

// *** tb/rpsel_periph_model.sv ***
// Purpose: Stands in for the on-chip peripherals, the port latches and the pin input levels.
// Assumes: Runs on the bus clock; every output changes just after a rising edge.
// Notes:   A shift pattern changes every cycle so that a stale or misrouted bit shows.
`timescale 1ns/10ps
module rpsel_periph_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	output logic      [18:0] periph_out,
	output logic      [9:0]  port_out,
	output logic      [25:0] pin_in
);
	logic [31:0] s_q;

	// Feedback shift register drives every far-side line with a fresh pattern each cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= 32'h1d2c_3b4a;
		end else begin
			s_q <= {s_q[30:0], s_q[31] ^ s_q[21] ^ s_q[1] ^ s_q[0]};
		end
	end

	// Slices of the pattern, overlapped so that the groups are not simple copies.
	assign periph_out = s_q[18:0];
	assign port_out   = s_q[28:19];
	assign pin_in     = s_q[31:6] ^ {s_q[12:0], s_q[25:13]};
endmodule : rpsel_periph_model
